// ### include/fm_audio_cfg.svh
// Register map, field positions, reset values and filter constants of the FM audio path
`ifndef FM_AUDIO_CFG_SVH
`define FM_AUDIO_CFG_SVH
`define ADDR_W 8
`define DATA_W 16
`define REG_CTRL 8'h00
`define REG_BL_RSSI_TH 8'h01
`define REG_BL_MP_TH 8'h02
`define REG_BL_RSSI_RT 8'h03
`define REG_BL_MP_RT 8'h04
`define REG_SM_TH 8'h05
`define REG_SM_RT 8'h06
`define REG_HC_SNR_TH 8'h07
`define REG_HC_RSSI_TH 8'h08
`define REG_HC_MP_TH 8'h09
`define REG_HC_SNR_RT 8'h0A
`define REG_HC_RSSI_RT 8'h0B
`define REG_HC_MP_RT 8'h0C
`define REG_HC_BW 8'h0D
`define CFG_COUNT 14
`define REG_MET_A 8'h10
`define REG_MET_B 8'h11
`define REG_AMT_A 8'h12
`define REG_AMT_B 8'h13
`define CTRL_DEEMPH75_BIT 0
`define CTRL_FM_BIT 1
`define CTRL_RESET 16'h0002
`define TH_BL_RESET 16'h2814
`define TH_SM_RESET 16'h1080
`define TH_HC_RESET 16'h3010
`define RT_RESET 16'h0401
`define HC_BW_DEFAULT 16'h00FF
`define DEEMPH_50_US 50
`define DEEMPH_75_US 75
`define DEEMPH_K50 9'h057
`define DEEMPH_K75 9'h03E
`define SUM_BW_KHZ 15
`define SUM_K 9'h063
`define GAIN_UNITY 9'h100
`define TARGET_SHIFT 3
`endif

// ### include/fm_audio_pkg.sv
// Types shared by the FM audio path modules
package fm_audio_pkg;
    typedef logic signed [15:0] sample_t;
    typedef logic [7:0] level_t;
    typedef logic [8:0] gain_t;
    typedef logic [15:0] word_t;
endpackage : fm_audio_pkg

// ### include/sample_fifo_if.sv
// Carrier between the audio datapath and its output buffer
`timescale 1ns/100ps
interface sample_fifo_if #(parameter int WIDTH = 32, parameter int LVL_W = 3);
    logic wrValid;
    logic [WIDTH-1:0] wrData;
    logic rdValid;
    logic rdReady;
    logic [WIDTH-1:0] rdData;
    logic [LVL_W-1:0] level;
    modport producer (output wrValid, output wrData, input level);
    modport buffer (input wrValid, input wrData, output level,
                    output rdValid, input rdReady, output rdData);
endinterface : sample_fifo_if

// ### rtl/sample_fifo.sv
// Small synchronous FIFO holding processed stereo samples
`timescale 1ns/100ps
module sample_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    sample_fifo_if.buffer fifo
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [0:DEPTH-1];
    logic [AW-1:0] wrPtr_q;
    logic [AW-1:0] rdPtr_q;
    logic [AW:0] count_q;
    logic notEmpty_q;
    wire doPush = fifo.wrValid && (count_q != (AW+1)'(DEPTH));
    wire doPop = fifo.rdReady && (count_q != '0);
    wire [AW:0] count_d = count_q + (AW+1)'(doPush) - (AW+1)'(doPop);

    // Producer must respect level; an overflowing write is dropped
    always_ff @(posedge core_clk) begin
        if (srst) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
            notEmpty_q <= 1'b0;
        end else begin
            if (doPush) begin
                mem[wrPtr_q] <= fifo.wrData;
                wrPtr_q <= (wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (doPop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1;
            end
            count_q <= count_d;
            notEmpty_q <= (count_d != '0);
        end
    end
    assign fifo.rdValid = notEmpty_q;
    assign fifo.rdData = mem[rdPtr_q];
    assign fifo.level = count_q;
endmodule : sample_fifo

// ### rtl/fm_stereo_audio_processor.sv
// FM stereo decode, blend, soft mute, hi-cut and de-emphasis with register port
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/100ps
`include "fm_audio_cfg.svh"

// Notes on behaviour
// RULE1: De-emphasis lowpass with 50 or 75 microsecond time constant from control bit.
// RULE2: Sum component, band limited to 15 kHz, is the mono audio.
// RULE3: Pilot-locked reference carrier demodulates the difference component.
// RULE4: Left is sum plus difference, right is sum minus difference.
// RULE5: Blend toward mono as RSSI or multipath SNR worsens.
// RULE6: Worst metric decides the blend amount.
// RULE7: Blend start and fully-blended levels are programmable per metric.
// RULE8: Each blend metric has its own attack and decay rate.
// RULE9: Pilot detection is readable by software.
// RULE10: Soft mute follows audio SNR and acts only in FM mode. Outside FM mode the code still applies a mute already built up while it decays.
// RULE11: Soft mute threshold, depth, attack and decay are programmable.
// RULE12: Hi-cut driven together by audio SNR, RSSI and multipath SNR.
// RULE13: Hi-cut min and max thresholds and attack and release rates per metric.
// RULE14: Hi-cut setting equal to default bandwidth disables hi-cut.
// RULE15: RSSI, SNR, multipath and pilot are monitored and readable.
// RULE16: One stereo sample per strobe; reset gives stereo, unmuted, full band.
// RULE17: Amounts move monotonically toward targets, step limited by programmed rate.
module fm_stereo_audio_processor #(
    parameter int FIFO_DEPTH = 4
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [`ADDR_W-1:0] regAddr,
    input wire fm_audio_pkg::word_t regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output fm_audio_pkg::word_t regRdata,
    input wire logic sampleValid,
    output logic sampleReady,
    input wire fm_audio_pkg::sample_t mpxSample,
    input wire fm_audio_pkg::sample_t pilotCarrier,
    input wire logic pilotDetect,
    input wire fm_audio_pkg::level_t rssi,
    input wire fm_audio_pkg::level_t snr,
    input wire fm_audio_pkg::level_t multipathSnr,
    input wire fm_audio_pkg::level_t audioSnr,
    output logic outValid,
    input wire logic outReady,
    output fm_audio_pkg::sample_t outLeft,
    output fm_audio_pkg::sample_t outRight
);
    import fm_audio_pkg::*;

    localparam int LVL_W = $clog2(FIFO_DEPTH) + 1;

    function automatic sample_t onePole(sample_t y, sample_t x, gain_t k);
        logic signed [16:0] diff;
        logic signed [26:0] prod;
        diff = 17'(x) - 17'(y);
        prod = diff * $signed({1'b0, k});
        onePole = sample_t'(y + sample_t'(prod >>> 8));
    endfunction : onePole

    function automatic sample_t scaleBy(sample_t x, gain_t g);
        logic signed [25:0] prod;
        prod = x * $signed({1'b0, g});
        scaleBy = sample_t'(prod >>> 8);
    endfunction : scaleBy

    // Amount 8'hFF means fully applied, so the pass gain reaches exactly zero
    function automatic gain_t passGain(level_t amt);
        passGain = (amt == 8'hFF) ? 9'h000 : `GAIN_UNITY - {1'b0, amt};
    endfunction : passGain

    // Start is the level where action begins, full where it is complete
    function automatic level_t targetOf(level_t m, level_t start, level_t full);
        logic [10:0] ramp;
        ramp = {3'b000, start - m} << `TARGET_SHIFT;
        if (m <= full) begin
            targetOf = 8'hFF;
        end else if (m >= start) begin
            targetOf = 8'h00;
        end else begin
            targetOf = (ramp > 11'h0FF) ? 8'hFF : ramp[7:0];
        end
    endfunction : targetOf

    function automatic level_t stepToward(level_t cur, level_t tgt, level_t up, level_t dn);
        if (tgt > cur) begin
            stepToward = (tgt - cur > up) ? cur + up : tgt;
        end else if (cur > tgt) begin
            stepToward = (cur - tgt > dn) ? cur - dn : tgt;
        end else begin
            stepToward = cur;
        end
    endfunction : stepToward

    function automatic word_t cfgReset(int idx);
        case (idx)
            0: cfgReset = `CTRL_RESET;
            1, 2: cfgReset = `TH_BL_RESET;
            5: cfgReset = `TH_SM_RESET;
            7, 8, 9: cfgReset = `TH_HC_RESET;
            13: cfgReset = `HC_BW_DEFAULT;
            default: cfgReset = `RT_RESET;
        endcase
    endfunction : cfgReset

    word_t cfg_q [0:`CFG_COUNT-1];
    word_t rdData_q;
    logic sampleReady_q;
    logic pilot_q;
    level_t rssi_q;
    level_t snr_q;
    level_t mp_q;
    level_t aSnr_q;
    level_t blend_q;
    level_t mute_q;
    level_t hicut_q;
    sample_t sum_q;
    sample_t diff_q;
    sample_t hcL_q;
    sample_t hcR_q;
    sample_t deL_q;
    sample_t deR_q;
    logic push_q;
    sample_t pushL_q;
    sample_t pushR_q;

    sample_fifo_if #(.WIDTH(32), .LVL_W(LVL_W)) fifoBus ();

    sample_fifo #(.WIDTH(32), .DEPTH(FIFO_DEPTH)) outFifo (
        .core_clk(core_clk),
        .srst(srst),
        .fifo(fifoBus)
    );

    // Register decode
    wire cfgHit = regAddr < `ADDR_W'(`CFG_COUNT);
    wire take = sampleValid && sampleReady_q;
    wire deemph75 = cfg_q[0][`CTRL_DEEMPH75_BIT];
    wire fmMode = cfg_q[0][`CTRL_FM_BIT];

    // Blend targets per metric; the worse one wins with its own rates
    wire level_t blRssiTgt = targetOf(rssi_q, cfg_q[1][15:8], cfg_q[1][7:0]); // see RULE7
    wire level_t blMpTgt = targetOf(mp_q, cfg_q[2][15:8], cfg_q[2][7:0]); // see RULE5
    wire blRssiWins = blRssiTgt >= blMpTgt; // see RULE6
    wire level_t blendTgt = blRssiWins ? blRssiTgt : blMpTgt;
    wire word_t blRate = blRssiWins ? cfg_q[3] : cfg_q[4]; // see RULE8
    wire level_t blend_d = stepToward(blend_q, blendTgt, blRate[15:8], blRate[7:0]);

    // Soft mute only engages in FM reception
    wire muteOn = fmMode && (aSnr_q < cfg_q[5][15:8]); // see RULE10
    wire level_t muteTgt = muteOn ? cfg_q[5][7:0] : 8'h00; // see RULE11
    wire level_t mute_d = stepToward(mute_q, muteTgt, cfg_q[6][15:8], cfg_q[6][7:0]);

    // Hi-cut from three metrics at once
    wire level_t hcSnrTgt = targetOf(aSnr_q, cfg_q[7][15:8], cfg_q[7][7:0]); // see RULE12
    wire level_t hcRssiTgt = targetOf(rssi_q, cfg_q[8][15:8], cfg_q[8][7:0]); // see RULE13
    wire level_t hcMpTgt = targetOf(mp_q, cfg_q[9][15:8], cfg_q[9][7:0]);
    wire hcSnrWins = (hcSnrTgt >= hcRssiTgt) && (hcSnrTgt >= hcMpTgt);
    wire hcRssiWins = !hcSnrWins && (hcRssiTgt >= hcMpTgt);
    wire level_t hicutTgt = hcSnrWins ? hcSnrTgt : (hcRssiWins ? hcRssiTgt : hcMpTgt);
    wire word_t hcRate = hcSnrWins ? cfg_q[10] : (hcRssiWins ? cfg_q[11] : cfg_q[12]);
    wire level_t hicut_d = stepToward(hicut_q, hicutTgt, hcRate[15:8], hcRate[7:0]);
    wire hcBypass = cfg_q[13] == `HC_BW_DEFAULT; // see RULE14
    wire gain_t hcFloor = {1'b0, cfg_q[13][7:0]} + 9'h001;
    wire gain_t hcRaw = `GAIN_UNITY - {1'b0, hicut_q};
    wire gain_t hcK = hcBypass ? `GAIN_UNITY : ((hcRaw < hcFloor) ? hcFloor : hcRaw);

    // Stereo decode: the reference carrier is locked to the pilot
    wire signed [31:0] mixProd = mpxSample * pilotCarrier; // see RULE3
    wire sample_t mixed = sample_t'(mixProd >>> 13);
    wire sample_t sum_d = onePole(sum_q, mpxSample, `SUM_K); // see RULE2
    wire sample_t diff_d = onePole(diff_q, mixed, `SUM_K);
    // Without pilot the path stays mono; blend then scales the rest
    wire gain_t diffGain = pilot_q ? passGain(blend_q) : 9'h000; // see RULE5
    wire sample_t diffEff = scaleBy(diff_q, diffGain);
    wire sample_t rawL = sample_t'(sum_q + diffEff); // see RULE4
    wire sample_t rawR = sample_t'(sum_q - diffEff); // see RULE4
    wire sample_t hcL_d = onePole(hcL_q, rawL, hcK);
    wire sample_t hcR_d = onePole(hcR_q, rawR, hcK);
    wire gain_t deK = deemph75 ? `DEEMPH_K75 : `DEEMPH_K50; // see RULE1
    wire sample_t deL_d = onePole(deL_q, hcL_d, deK);
    wire sample_t deR_d = onePole(deR_q, hcR_d, deK);
    wire gain_t muteGain = passGain(mute_q);

    // Ready lags a cycle and push lags take, so three more words may still land
    wire ready_d = fifoBus.level <= LVL_W'(FIFO_DEPTH - 3);

    wire word_t rdMux =
        (regAddr == `REG_MET_A) ? {rssi_q, snr_q} : // see RULE15
        (regAddr == `REG_MET_B) ? {mp_q, aSnr_q} :
        (regAddr == `REG_AMT_A) ? {blend_q, mute_q} :
        (regAddr == `REG_AMT_B) ? {hicut_q, 7'h00, pilot_q} : // see RULE9
        cfgHit ? cfg_q[regAddr[3:0]] : 16'h0000;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            for (int i = 0; i < `CFG_COUNT; i++) begin
                cfg_q[i] <= cfgReset(i);
            end
        end else if (regWr && cfgHit) begin
            cfg_q[regAddr[3:0]] <= regWdata;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            rdData_q <= 16'h0000;
            sampleReady_q <= 1'b0;
        end else begin
            rdData_q <= regRd ? rdMux : 16'h0000;
            sampleReady_q <= ready_d;
        end
    end

    // Metric snapshot, refreshed every cycle
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pilot_q <= 1'b0;
            rssi_q <= 8'h00;
            snr_q <= 8'h00;
            mp_q <= 8'h00;
            aSnr_q <= 8'h00;
        end else begin
            pilot_q <= pilotDetect;
            rssi_q <= rssi;
            snr_q <= snr;
            mp_q <= multipathSnr;
            aSnr_q <= audioSnr;
        end
    end

    // Control amounts step once per accepted sample
    always_ff @(posedge core_clk) begin
        if (srst) begin
            blend_q <= 8'h00; // see RULE16
            mute_q <= 8'h00;
            hicut_q <= 8'h00;
        end else if (take) begin
            blend_q <= blend_d; // see RULE17
            mute_q <= mute_d;
            hicut_q <= hicut_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            sum_q <= '0;
            diff_q <= '0;
            hcL_q <= '0;
            hcR_q <= '0;
            deL_q <= '0;
            deR_q <= '0;
        end else if (take) begin
            sum_q <= sum_d;
            diff_q <= diff_d;
            hcL_q <= hcL_d;
            hcR_q <= hcR_d;
            deL_q <= deL_d;
            deR_q <= deR_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            push_q <= 1'b0;
            pushL_q <= '0;
            pushR_q <= '0;
        end else begin
            push_q <= take; // see RULE16
            pushL_q <= scaleBy(deL_d, muteGain);
            pushR_q <= scaleBy(deR_d, muteGain);
        end
    end

    assign fifoBus.wrValid = push_q;
    assign fifoBus.wrData = {pushL_q, pushR_q};
    assign fifoBus.rdReady = outReady;
    assign outValid = fifoBus.rdValid;
    assign outLeft = fifoBus.rdData[31:16];
    assign outRight = fifoBus.rdData[15:0];
    assign regRdata = rdData_q;
    assign sampleReady = sampleReady_q;

    // Checks
    sequence seqTakeNoPilot;
        take && !pilot_q && (diff_q != '0);
    endsequence

    sequence seqPushEqual;
        ##1 push_q && (pushL_q == pushR_q);
    endsequence

    AST_RESET_CLEAR: assert property (@(posedge core_clk) // see RULE16
        srst |=> (blend_q == 8'h00) && (mute_q == 8'h00) && (hicut_q == 8'h00))
        else $error("Amounts not cleared by reset");

    AST_MONO_NO_PILOT: assert property (@(posedge core_clk) disable iff (srst) // see RULE4
        seqTakeNoPilot |-> seqPushEqual)
        else $error("Left and right differ without pilot");

    AST_BLEND_WORST: assert property (@(posedge core_clk) disable iff (srst) // see RULE6
        take && ((blRssiTgt > blend_q) || (blMpTgt > blend_q)) |=> blend_q >= $past(blend_q))
        else $error("Blend backs off while a metric is worse");

    AST_BLEND_RATE: assert property (@(posedge core_clk) disable iff (srst) // see RULE8
        take && (blendTgt > blend_q) |=> (blend_q - $past(blend_q)) <= $past(blRate[15:8]))
        else $error("Blend attack step exceeds rate");

    AST_STEP_MONOTONIC: assert property (@(posedge core_clk) disable iff (srst) // see RULE17
        take && (muteTgt <= mute_q) |=> (mute_q <= $past(mute_q)) && (mute_q >= $past(muteTgt)))
        else $error("Mute not monotonic toward target");

    AST_MUTE_FM_ONLY: assert property (@(posedge core_clk) disable iff (srst) // see RULE10
        !fmMode && (mute_q == 8'h00) |=> (mute_q == 8'h00))
        else $error("Soft mute outside FM mode");

    AST_HC_BYPASS: assert property (@(posedge core_clk) disable iff (srst) // see RULE14
        take && hcBypass |=> (hcL_q == $past(rawL)) && (hcR_q == $past(rawR)))
        else $error("Hi-cut active at default bandwidth");

    AST_PILOT_READ: assert property (@(posedge core_clk) disable iff (srst) // see RULE9
        regRd && (regAddr == `REG_AMT_B) |=> regRdata[0] == $past(pilot_q))
        else $error("Pilot flag not read back");

    AST_HOLD_IDLE: assert property (@(posedge core_clk) disable iff (srst) // see RULE16
        !take |=> $stable(blend_q) && $stable(hicut_q) && $stable(sum_q))
        else $error("State moved without sample");

    AST_NO_OVERFLOW: assert property (@(posedge core_clk) disable iff (srst)
        push_q |-> fifoBus.level < LVL_W'(FIFO_DEPTH))
        else $error("Output buffer overflow");

    AST_BLEND_DECAY: assert property (@(posedge core_clk) disable iff (srst) // see RULE8
        take && (blendTgt < blend_q) |=> ($past(blend_q) - blend_q) <= $past(blRate[7:0]))
        else $error("Blend decay step exceeds rate");

    AST_MUTE_RATE: assert property (@(posedge core_clk) disable iff (srst) // see RULE11
        take && (muteTgt > mute_q) |=> (mute_q - $past(mute_q)) <= $past(cfg_q[6][15:8]))
        else $error("Mute attack step exceeds rate");

    AST_HC_RATE: assert property (@(posedge core_clk) disable iff (srst) // see RULE13
        take && (hicutTgt > hicut_q) |=> (hicut_q - $past(hicut_q)) <= $past(hcRate[15:8]))
        else $error("Hi-cut attack step exceeds rate");

    AST_ONE_PUSH: assert property (@(posedge core_clk) disable iff (srst) // see RULE16
        take |=> push_q)
        else $error("Accepted sample not pushed");

    AST_READ_IDLE: assert property (@(posedge core_clk) disable iff (srst) // see RULE15
        !regRd |=> (regRdata == 16'h0000))
        else $error("Read data outside read cycle");
endmodule : fm_stereo_audio_processor

// ### tb/audio_sink_model.sv
// Downstream audio path model that pops stereo pairs with random stalls
`timescale 1ns/100ps
module audio_sink_model (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic holdOff,
    input wire logic outValid,
    input wire fm_audio_pkg::sample_t outLeft,
    input wire fm_audio_pkg::sample_t outRight,
    output logic outReady,
    output int nPopped,
    output int nStereo
);
    import fm_audio_pkg::*;
    // Random ready keeps the buffer partly full most of the time
    always @(posedge core_clk) begin
        if (srst) begin
            outReady <= 1'b0;
            nPopped <= 0;
            nStereo <= 0;
        end else begin
            if (outValid === 1'b1 && outReady === 1'b1) begin
                nPopped <= nPopped + 1;
                if (outLeft !== outRight) begin
                    nStereo <= nStereo + 1;
                end
            end
            outReady <= !holdOff && ($urandom % 4 != 0);
        end
    end
endmodule : audio_sink_model

// ### tb/tb_fm_stereo_audio_processor.sv
// Self-checking bench of the FM audio path: registers, blend, mute, buffering
`timescale 1ns/100ps
`include "fm_audio_cfg.svh"
module tb_fm_stereo_audio_processor;
    import fm_audio_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic [7:0] regAddr = 8'h00;
    word_t regWdata = 16'h0000;
    logic regWr = 1'b0;
    logic regRd = 1'b0;
    word_t regRdata;
    logic sampleValid = 1'b0;
    logic sampleReady;
    sample_t mpxSample = 16'h0000;
    sample_t pilotCarrier = 16'h0000;
    logic pilotDetect = 1'b0;
    level_t rssi = 8'hC8;
    level_t snr = 8'hC8;
    level_t multipathSnr = 8'hC8;
    level_t audioSnr = 8'hC8;
    logic outValid, outReady;
    logic holdOff = 1'b0;
    sample_t outLeft, outRight;
    int nPopped, nStereo, t;
    int n_mismatch = 0;
    int num_checks = 0;
    int nTaken = 0;
    int blendAmt = 0;
    word_t d, w;
    logic [31:0] m4;
    word_t rstTab [14] = '{`CTRL_RESET, `TH_BL_RESET, `TH_BL_RESET, `RT_RESET, `RT_RESET,
        `TH_SM_RESET, `RT_RESET, `TH_HC_RESET, `TH_HC_RESET, `TH_HC_RESET, `RT_RESET,
        `RT_RESET, `RT_RESET, `HC_BW_DEFAULT};

    always #25 core_clk = ~core_clk;

    fm_stereo_audio_processor #(.FIFO_DEPTH(4)) dut_u (.core_clk(core_clk), .srst(srst),
        .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
        .regRdata(regRdata), .sampleValid(sampleValid), .sampleReady(sampleReady),
        .mpxSample(mpxSample), .pilotCarrier(pilotCarrier), .pilotDetect(pilotDetect),
        .rssi(rssi), .snr(snr), .multipathSnr(multipathSnr), .audioSnr(audioSnr),
        .outValid(outValid), .outReady(outReady), .outLeft(outLeft), .outRight(outRight));

    audio_sink_model sink_u (.core_clk(core_clk), .srst(srst), .holdOff(holdOff),
        .outValid(outValid), .outLeft(outLeft), .outRight(outRight),
        .outReady(outReady), .nPopped(nPopped), .nStereo(nStereo));

    task automatic complete_run;
        $display("Checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : complete_run

    task automatic check_val(input string name, input word_t exp, input word_t got);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask : check_val

    task automatic reg_write(input logic [7:0] a, input word_t v);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge core_clk);
        regWr <= 1'b0;
        @(posedge core_clk);
    endtask : reg_write

    task automatic reg_read(input logic [7:0] a, output word_t q);
        regRd <= 1'b1;
        regAddr <= a;
        @(posedge core_clk);
        regRd <= 1'b0;
        @(negedge core_clk);
        q = regRdata;
        @(posedge core_clk);
    endtask : reg_read

    // Ready is registered, so its value before the edge decides the take
    task automatic send_samples(input int n, input int maxCyc, output int took);
        int cyc;
        logic rdy;
        took = 0;
        cyc = 0;
        sampleValid <= 1'b1;
        mpxSample <= sample_t'($urandom);
        pilotCarrier <= sample_t'($urandom);
        while (took < n && cyc < maxCyc) begin
            @(negedge core_clk);
            rdy = sampleReady;
            @(posedge core_clk);
            cyc++;
            if (rdy === 1'b1) begin
                took++;
                mpxSample <= sample_t'($urandom);
                pilotCarrier <= sample_t'($urandom);
            end
        end
        sampleValid <= 1'b0;
        nTaken += took;
        repeat (2) @(posedge core_clk);
    endtask : send_samples

    task automatic drain;
        int k;
        k = 0;
        do begin
            @(negedge core_clk);
            k++;
        end while (outValid !== 1'b0 && k < 300);
        repeat (3) @(posedge core_clk);
    endtask : drain

    function automatic int blend_tgt(input int m, input int th);
        int hi, lo;
        hi = th >> 8;
        lo = th & 255;
        if (m <= lo) return 255;
        if (m >= hi) return 0;
        return ((hi - m) * 8 > 255) ? 255 : (hi - m) * 8;
    endfunction : blend_tgt

    // RSSI thresholds 0x3018 with rates 6/2, multipath at reset with rates 3/1
    task automatic blend_phase(input int r, input int mp, input int n);
        int tR, tM, tg, st, k;
        rssi <= level_t'(r);
        multipathSnr <= level_t'(mp);
        repeat (3) @(posedge core_clk);
        tR = blend_tgt(r, 16'h3018);
        tM = blend_tgt(mp, `TH_BL_RESET);
        tg = (tR > tM) ? tR : tM;
        repeat (n) begin
            send_samples(1, 100, k);
            if (blendAmt < tg) begin
                st = (tR >= tM) ? 6 : 3;
                blendAmt = (tg - blendAmt > st) ? blendAmt + st : tg;
            end else begin
                st = (tR >= tM) ? 2 : 1;
                blendAmt = (blendAmt - tg > st) ? blendAmt - st : tg;
            end
            reg_read(`REG_AMT_A, d);
            check_val("blendAmount", 16'(blendAmt), {8'h00, d[15:8]});
        end
    endtask : blend_phase

    initial begin
        repeat (60000) @(posedge core_clk);
        n_mismatch++;
        $display("Watchdog expired before the tests ended");
        complete_run();
    end

    initial begin
        void'($urandom(32'hA87B4168));
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        for (int a = 0; a < `CFG_COUNT; a++) begin
            reg_read(8'(a), d);
            check_val("resetValue", rstTab[a], d);
        end
        reg_read(`REG_AMT_A, d);
        check_val("resetAmounts", 16'h0000, d);
        for (int a = 0; a < `CFG_COUNT; a++) begin
            w = word_t'($urandom);
            reg_write(8'(a), w);
            reg_read(8'(a), d);
            check_val("readBack", w, d);
            reg_write(8'(a), rstTab[a]);
        end
        reg_write(8'h0E, 16'h5A5A);
        reg_read(8'h0E, d);
        check_val("unmapped", 16'h0000, d);
        for (int p = 0; p < 2; p++) begin
            m4 = $urandom;
            {rssi, snr, multipathSnr, audioSnr} <= m4;
            pilotDetect <= p[0];
            repeat (3) @(posedge core_clk);
            reg_read(`REG_MET_A, d);
            check_val("metricsA", m4[31:16], d);
            reg_read(`REG_MET_B, d);
            check_val("metricsB", m4[15:0], d);
            reg_read(`REG_AMT_B, d);
            check_val("pilotFlag", {15'h0000, p[0]}, {15'h0000, d[0]});
        end
        {rssi, snr, multipathSnr, audioSnr} <= 32'hC8C8C8C8;
        pilotDetect <= 1'b0;
        send_samples(16, 400, t);
        drain();
        check_val("monoPairs", 16'h0000, 16'(nStereo));
        pilotDetect <= 1'b1;
        send_samples(16, 400, t);
        drain();
        check_val("stereoSeen", 16'h0001, {15'h0000, nStereo > 0});
        check_val("pairCount", 16'(nTaken), 16'(nPopped));
        holdOff <= 1'b1;
        repeat (2) @(posedge core_clk);
        send_samples(10, 12, t);
        check_val("stallTaken", 16'h0004, 16'(t));
        @(negedge core_clk);
        check_val("stallFlags", 16'h0001, {14'h0000, sampleReady, outValid});
        @(posedge core_clk);
        holdOff <= 1'b0;
        drain();
        check_val("pairCount", 16'(nTaken), 16'(nPopped));
        reg_write(`REG_BL_RSSI_TH, 16'h3018);
        reg_write(`REG_BL_RSSI_RT, 16'h0602);
        reg_write(`REG_BL_MP_RT, 16'h0301);
        blend_phase(25 + $urandom % 23, 40 + $urandom % 200, 20);
        blend_phase(30, $urandom % 21, 30);
        blend_phase(41 + $urandom % 7, 200, 20);
        reg_write(`REG_CTRL, 16'h0000);
        audioSnr <= 8'h05;
        send_samples(12, 200, t);
        reg_read(`REG_AMT_A, d);
        check_val("muteFmOff", 16'h0000, {8'h00, d[7:0]});
        reg_write(`REG_CTRL, `CTRL_RESET);
        send_samples(12, 200, t);
        reg_read(`REG_AMT_A, d);
        check_val("muteOn", 16'(12 * (`RT_RESET >> 8)), {8'h00, d[7:0]});
        drain();
        check_val("pairCount", 16'(nTaken), 16'(nPopped));
        complete_run();
    end
endmodule : tb_fm_stereo_audio_processor
